// ---- twd_debug_regs.sv ----
// Contract
// - these registers are reached only over the two-wire debug link
// - an 8-bit target select register picks the data register for data commands
// - select 0x00 makes data reads return the device identity
// - select 0x01 makes data reads return the silicon revision
// - select 0x02 makes data reads and writes use flash program control
// - select 0xb4 makes data reads and writes use the flash program channel
// - the channel is the single byte path for flash commands, addresses, data
// - channel codes 0x06, 0x07, 0x08, 0x03 are read, write, page erase, device erase
// - while halted the device stalls peripherals and user program execution
// - link clock shares the reset pin, link data the shared port pin when halted
// - the link is one host-driven clock and one two-way data line
`default_nettype none
module twd_debug_regs
    import twd_pkg::*;
#(
    parameter logic [7:0] DEVICE_IDENTITY  = 8'ha5, // arbitrary value
    parameter logic [7:0] SILICON_REVISION = 8'h01  // arbitrary value
) (
    input  wire logic           i_sys_clk,        // system clock, 200 MHz
    input  wire logic           i_rst,            // synchronous reset, active high
    input  wire logic           i_halt,           // core is in the halt state
    input  wire logic           i_link_clk,       // debug_link_clock from the shared reset pin
    input  wire logic           i_link_data_i,    // debug_link_data level on the shared port pin
    output logic                o_link_data_o,    // debug_link_data drive value
    output logic                o_link_data_oe,   // debug_link_data drive enable
    output logic                o_stall,          // stall peripherals and program execution
    output logic                o_port_user_en,   // user logic owns shared_port_pin
    output logic [7:0]          o_flash_control,  // flash_program_control contents
    output twd_flash_req_t      o_flash_req,      // command, argument and error strobes
    input  wire logic           i_flash_rd_stb,   // flash engine offers a read byte
    input  wire logic [7:0]     i_flash_rd_byte,  // byte to show in the channel
    input  wire logic           i_flash_done      // flash engine finished the command
);

    // ---------------- system domain ----------------
    logic          stall_q;
    logic          user_en_q;
    logic [7:0]    control_q;
    twd_flash_req_t req_q;
    twd_chan_st_t  cst_q;
    logic [7:0]    rd_byte_q;
    logic          rd_tog_q;
    logic          wt_m_q;
    logic          wt_s_q;
    logic          wt_seen_q;
    logic          wr_evt;

    // ---------------- link domain ----------------
    logic          rst_m_q;
    logic          rst_l_q;
    logic          halt_m_q;
    logic          halt_l_q;
    logic          rt_m_q;
    logic          rt_l_q;
    logic          rt_seen_q;
    twd_link_st_t  lst_q;
    logic [2:0]    cnt_q;
    logic [1:0]    op_q;
    logic [7:0]    sh_q;
    logic [7:0]    select_q;
    logic [7:0]    ctl_shadow_q;
    logic [7:0]    chan_in_q;
    logic [7:0]    wr_byte_q;
    logic          wr_to_chan_q;
    logic          wr_tog_q;
    logic          dout_q;
    logic          doe_q;
    logic [7:0]    wbyte;
    logic [7:0]    rvalue;

    // halt stalls everything else and hands the shared port pin to the link
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            stall_q   <= 1'b0;
            user_en_q <= 1'b1;
        end else begin
            stall_q   <= i_halt;
            user_en_q <= ~i_halt;
        end
    end

    // write events from the link arrive as a toggle
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wt_m_q    <= 1'b0;
            wt_s_q    <= 1'b0;
            wt_seen_q <= 1'b0;
        end else begin
            wt_m_q    <= wr_tog_q;
            wt_s_q    <= wt_m_q;
            wt_seen_q <= wt_s_q;
        end
    end

    // wr_byte_q and wr_to_chan_q are stable for many link edges after a toggle
    assign wr_evt = wt_s_q ^ wt_seen_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            control_q <= TWD_CONTROL_RST;
        end else if (wr_evt && !wr_to_chan_q) begin
            control_q <= wr_byte_q;
        end
    end

    // first channel byte is a command, later ones are its arguments
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cst_q <= TWD_C_WAIT_CMD;
            req_q <= '0;
        end else begin
            req_q.cmd_stb <= 1'b0;
            req_q.bad_stb <= 1'b0;
            req_q.arg_stb <= 1'b0;
            if (wr_evt && wr_to_chan_q) begin
                unique case (cst_q)
                    TWD_C_WAIT_CMD: begin
                        cst_q         <= TWD_C_ARGS;
                        req_q.cmd_stb <= 1'b1;
                        unique case (wr_byte_q)
                            TWD_CMD_BLOCK_READ:   req_q.cmd <= TWD_F_BLOCK_READ;
                            TWD_CMD_BLOCK_WRITE:  req_q.cmd <= TWD_F_BLOCK_WRITE;
                            TWD_CMD_PAGE_ERASE:   req_q.cmd <= TWD_F_PAGE_ERASE;
                            TWD_CMD_DEVICE_ERASE: req_q.cmd <= TWD_F_DEVICE_ERASE;
                            default: begin
                                // unknown codes are refused and the channel waits again
                                cst_q         <= TWD_C_WAIT_CMD;
                                req_q.cmd_stb <= 1'b0;
                                req_q.bad_stb <= 1'b1;
                                req_q.cmd     <= TWD_F_NONE;
                            end
                        endcase
                    end
                    TWD_C_ARGS: begin
                        req_q.arg_stb <= 1'b1;
                        req_q.arg     <= wr_byte_q;
                    end
                endcase
            end else if (i_flash_done) begin
                cst_q     <= TWD_C_WAIT_CMD;
                req_q.cmd <= TWD_F_NONE;
            end
        end
    end

    // read bytes go back toward the link as data plus toggle
    // limitation: strobes closer than three link edges apart can hand the link a changing byte
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rd_byte_q <= TWD_CHANNEL_RST;
            rd_tog_q  <= 1'b0;
        end else if (i_flash_rd_stb) begin
            rd_byte_q <= i_flash_rd_byte;
            rd_tog_q  <= ~rd_tog_q;
        end
    end

    assign o_stall         = stall_q;
    assign o_port_user_en  = user_en_q;
    assign o_flash_control = control_q;
    assign o_flash_req     = req_q;

    // link reset and halt need link edges to take effect; the host clocks
    // idle bits after reset so that both settle before a frame
    always_ff @(posedge i_link_clk) begin
        rst_m_q  <= i_rst;
        rst_l_q  <= rst_m_q;
        halt_m_q <= stall_q;
        halt_l_q <= halt_m_q;
    end

    // a new read byte is caught on the third link edge after its toggle; until then reads show the old one
    always_ff @(posedge i_link_clk) begin
        if (rst_l_q) begin
            rt_m_q    <= 1'b0;
            rt_l_q    <= 1'b0;
            rt_seen_q <= 1'b0;
            chan_in_q <= TWD_CHANNEL_RST;
        end else begin
            rt_m_q    <= rd_tog_q;
            rt_l_q    <= rt_m_q;
            rt_seen_q <= rt_l_q;
            if (rt_l_q != rt_seen_q) begin
                chan_in_q <= rd_byte_q;
            end
        end
    end

    // byte being completed on this edge, least significant bit first
    assign wbyte = {i_link_data_i, sh_q[7:1]};

    always_comb begin
        rvalue = 8'h00;
        if (op_q == TWD_OP_ADDR_RD) begin
            rvalue = select_q;
        end else begin
            unique case (select_q)
                TWD_SEL_IDENTITY: rvalue = DEVICE_IDENTITY;
                TWD_SEL_REVISION: rvalue = SILICON_REVISION;
                TWD_SEL_CONTROL:  rvalue = ctl_shadow_q;
                TWD_SEL_CHANNEL:  rvalue = chan_in_q;
                default:          rvalue = 8'h00;
            endcase
        end
    end

    // frame sequencer: registers exist only behind this link
    always_ff @(posedge i_link_clk) begin
        if (rst_l_q) begin
            lst_q        <= TWD_L_IDLE;
            cnt_q        <= 3'h0;
            op_q         <= 2'b00;
            sh_q         <= 8'h00;
            select_q     <= TWD_SELECT_RST;
            ctl_shadow_q <= TWD_CONTROL_RST;
            wr_byte_q    <= 8'h00;
            wr_to_chan_q <= 1'b0;
            wr_tog_q     <= 1'b0;
            dout_q       <= 1'b0;
            doe_q        <= 1'b0;
        end else if (!halt_l_q) begin
            // the pin belongs to user logic while running; drop any frame
            lst_q <= TWD_L_IDLE;
            doe_q <= 1'b0;
        end else begin
            unique case (lst_q)
                TWD_L_IDLE: begin
                    cnt_q <= 3'h0;
                    if (i_link_data_i) begin
                        lst_q <= TWD_L_INSTR;
                    end
                end
                TWD_L_INSTR: begin
                    op_q[cnt_q[0]] <= i_link_data_i;
                    cnt_q          <= cnt_q + 3'h1;
                    if (cnt_q == TWD_INSTR_LAST) begin
                        cnt_q <= 3'h0;
                        // op bit 1 arrives now, bit 0 was stored last edge
                        if ({i_link_data_i, op_q[0]} == TWD_OP_DATA_RD
                            || {i_link_data_i, op_q[0]} == TWD_OP_ADDR_RD) begin
                            lst_q <= TWD_L_TURN;
                        end else begin
                            lst_q <= TWD_L_WDATA;
                        end
                    end
                end
                TWD_L_WDATA: begin
                    sh_q  <= wbyte;
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == TWD_WBYTE_LAST) begin
                        lst_q <= TWD_L_IDLE;
                        if (op_q == TWD_OP_ADDR_WR) begin
                            select_q <= wbyte;
                        end else if (select_q == TWD_SEL_CONTROL) begin
                            ctl_shadow_q <= wbyte;
                            wr_byte_q    <= wbyte;
                            wr_to_chan_q <= 1'b0;
                            wr_tog_q     <= ~wr_tog_q;
                        end else if (select_q == TWD_SEL_CHANNEL) begin
                            wr_byte_q    <= wbyte;
                            wr_to_chan_q <= 1'b1;
                            wr_tog_q     <= ~wr_tog_q;
                        end
                        // writes to identity, revision or unmapped codes are dropped
                    end
                end
                TWD_L_TURN: begin
                    doe_q  <= 1'b1;
                    dout_q <= rvalue[0];
                    sh_q   <= {1'b0, rvalue[7:1]};
                    lst_q  <= TWD_L_RDATA;
                end
                TWD_L_RDATA: begin
                    dout_q <= sh_q[0];
                    sh_q   <= {1'b0, sh_q[7:1]};
                    cnt_q  <= cnt_q + 3'h1;
                    if (cnt_q == TWD_RBYTE_LAST) begin
                        lst_q <= TWD_L_STOP;
                    end
                end
                TWD_L_STOP: begin
                    // release costs one extra edge so the line never floats mid-byte
                    doe_q <= 1'b0;
                    lst_q <= TWD_L_IDLE;
                end
                default: begin
                    lst_q <= TWD_L_IDLE;
                    doe_q <= 1'b0;
                end
            endcase
        end
    end

    assign o_link_data_o  = dout_q;
    assign o_link_data_oe = doe_q;

endmodule // twd_debug_regs
`default_nettype wire

// ---- twd_debug_regs_properties.sv ----
`default_nettype none
module twd_debug_regs_chk
    import twd_pkg::*;
(
    input wire logic           i_sys_clk,      // system clock
    input wire logic           i_rst,          // synchronous reset
    input wire logic           i_halt,         // core halted
    input wire logic           i_link_clk,     // link clock
    input wire logic           i_link_data_i,  // link data level
    input wire logic           i_flash_done,   // flash command finished
    input wire logic           o_link_data_oe, // link data drive enable
    input wire logic           o_stall,        // stall output
    input wire logic           o_port_user_en, // user owns shared pin
    input wire twd_flash_req_t o_flash_req     // flash request strobes
);
    timeunit 1ns;
    timeprecision 100ps;
    sequence s_read_header;
        $past(i_link_data_i, 4) && !$past(i_link_data_i, 3);
    endsequence
    sequence s_read_burst;
        o_link_data_oe [*8] ##1 !o_link_data_oe;
    endsequence
    a_stall_halt: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !$past(i_rst) |-> o_stall == $past(i_halt)) else $error("stall does not follow halt");
    a_port_owner: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_port_user_en == !o_stall) else $error("shared pin owner wrong");
    a_cmd_pulse: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_flash_req.cmd_stb |=> !o_flash_req.cmd_stb) else $error("command strobe too long");
    a_bad_pulse: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_flash_req.bad_stb |=> !o_flash_req.bad_stb) else $error("bad strobe too long");
    a_arg_pulse: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_flash_req.arg_stb |=> !o_flash_req.arg_stb) else $error("argument strobe too long");
    a_cmd_code: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_flash_req.cmd_stb |-> o_flash_req.cmd inside {TWD_F_BLOCK_READ, TWD_F_BLOCK_WRITE,
        TWD_F_PAGE_ERASE, TWD_F_DEVICE_ERASE} && !o_flash_req.bad_stb && !o_flash_req.arg_stb)
        else $error("command strobe without valid code");
    a_cmd_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (o_flash_req.cmd != TWD_F_NONE && !i_flash_done) |=> (o_flash_req.cmd_stb || $stable(o_flash_req.cmd)))
        else $error("command level dropped early");
    a_read_start: assert property (@(posedge i_link_clk) disable iff (i_rst)
        $rose(o_link_data_oe) |-> s_read_header) else $error("drive without read header");
    a_read_span: assert property (@(posedge i_link_clk) disable iff (i_rst)
        $rose(o_link_data_oe) |-> s_read_burst) else $error("read drive span wrong");
endmodule // twd_debug_regs_chk
bind twd_debug_regs twd_debug_regs_chk u_chk (.i_sys_clk, .i_rst, .i_halt, .i_link_clk, .i_link_data_i,
    .i_flash_done, .o_link_data_oe, .o_stall, .o_port_user_en, .o_flash_req);
`default_nettype wire

// ---- twd_debug_regs_tb.sv ----
`default_nettype none
module twd_debug_regs_tb
    import twd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
    localparam logic [7:0] REV_VAL = 8'h02; // arbitrary value
    localparam logic [7:0] CODES [4] = '{TWD_CMD_BLOCK_READ, TWD_CMD_BLOCK_WRITE, TWD_CMD_PAGE_ERASE,
        TWD_CMD_DEVICE_ERASE};
    localparam twd_fcmd_t FCMDS [4] = '{TWD_F_BLOCK_READ, TWD_F_BLOCK_WRITE, TWD_F_PAGE_ERASE, TWD_F_DEVICE_ERASE};
    logic clk = 1'b0, rst = 1'b1, halt = 1'b0, rd_stb = 1'b0, done = 1'b0, link_clk, data_o, oe, stall, user_en;
    logic [7:0] rd_byte = 8'h00, ctrl, r, sel_m = 8'h00, ctrl_m = 8'h00, rdb_m = 8'h00;
    wire logic link_line;
    twd_flash_req_t req;
    twd_flash_req_t evq [$];
    int fails = 0, cmp_count = 0, oe_hits = 0;
    logic chan_args = 1'b0;
    twd_fcmd_t cmd_m = TWD_F_NONE;
    logic [15:0] seed = 16'hd00a;
    twd_debug_regs #(.DEVICE_IDENTITY(ID_VAL), .SILICON_REVISION(REV_VAL)) DUT (
        .i_sys_clk(clk), .i_rst(rst), .i_halt(halt), .i_link_clk(link_clk), .i_link_data_i(link_line),
        .o_link_data_o(data_o), .o_link_data_oe(oe), .o_stall(stall), .o_port_user_en(user_en),
        .o_flash_control(ctrl), .o_flash_req(req), .i_flash_rd_stb(rd_stb), .i_flash_rd_byte(rd_byte),
        .i_flash_done(done));
    twd_host_model u_host (.o_link_clk(link_clk), .o_link_line(link_line), .i_dev_data(data_o), .i_dev_oe(oe));
    always #2.5 clk = ~clk;
    always @(posedge clk) if (!rst && (req.cmd_stb | req.bad_stb | req.arg_stb) === 1'b1) evq.push_back(req);
    always @(posedge link_clk) if (!rst && !halt && oe !== 1'b0) oe_hits++;
    function automatic logic [7:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] model_rd(logic [7:0] s);
        case (s)
            8'h00: return ID_VAL;
            8'h01: return REV_VAL;
            8'h02: return ctrl_m;
            8'hb4: return rdb_m;
            default: return 8'h00;
        endcase
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic addr_wr(input logic [7:0] v);
        u_host.frame(2'b01, v, r);
        sel_m = v;
    endtask
    task automatic data_rd();
        u_host.frame(2'b00, 8'h00, r);
        check("data_read", r, model_rd(sel_m));
    endtask
    task automatic data_wr(input logic [7:0] v);
        twd_flash_req_t got;
        logic [7:0] ef;
        u_host.frame(2'b11, v, r);
        repeat (4) @(posedge clk);
        if (sel_m == 8'h02) ctrl_m = v;
        check("control", ctrl, ctrl_m);
        check("events", 8'(evq.size()), {7'h00, sel_m == 8'hb4});
        got = (evq.size() > 0) ? evq.pop_front() : '0;
        evq.delete();
        if (sel_m == 8'hb4) begin
            ef = {2'b00, 1'b0, TWD_F_NONE, 2'b10};
            if (chan_args) ef = {2'b00, 1'b0, cmd_m, 2'b01};
            else for (int i = 0; i < 4; i++) if (v == CODES[i]) begin
                cmd_m = FCMDS[i];
                ef = {2'b00, 1'b1, cmd_m, 2'b00};
            end
            if (ef[5]) chan_args = 1'b1;
            check("req_flags", {2'b00, got.cmd_stb, got.cmd, got.bad_stb, got.arg_stb}, ef);
            if (ef[0]) check("arg", got.arg, v);
        end
    endtask
    initial begin
        logic [7:0] v;
        fork
            repeat (20) @(posedge clk);
            u_host.idle(4);
        join
        @(posedge clk) #1 rst = 1'b0;
        @(posedge clk) #1 check("stall", {7'h00, stall}, 8'h00);
        check("user_en", {7'h00, user_en}, 8'h01);
        check("req_idle", {7'h00, req !== '0}, 8'h00);
        halt = 1'b1;
        repeat (3) @(posedge clk);
        u_host.idle(3);
        check("stall", {7'h00, stall}, 8'h01);
        check("user_en", {7'h00, user_en}, 8'h00);
        u_host.frame(2'b10, 8'h00, r);
        check("select", r, 8'h00);
        data_rd();
        data_wr(8'h5a);
        data_rd();
        addr_wr(8'h01);
        data_wr(rnd());
        data_rd();
        addr_wr(TWD_SEL_CONTROL);
        repeat (3) begin
            data_wr(rnd());
            data_rd();
        end
        v = rnd();
        if (v inside {8'h00, 8'h01, 8'h02, 8'hb4}) v = 8'h55;
        addr_wr(v);
        u_host.frame(2'b10, 8'h00, r);
        check("select", r, v);
        data_wr(rnd());
        data_rd();
        addr_wr(TWD_SEL_CHANNEL);
        for (int i = 0; i < 4; i++) begin
            data_wr(CODES[i]);
            data_wr(rnd());
            data_wr(rnd());
            data_rd();
            @(posedge clk) #1 done = 1'b1;
            @(posedge clk) #1 done = 1'b0;
            chan_args = 1'b0;
            cmd_m = TWD_F_NONE;
            repeat (3) @(posedge clk);
            check("cmd_level", {5'h00, req.cmd}, {5'h00, TWD_F_NONE});
        end
        data_wr(8'h0f);
        data_wr(TWD_CMD_DEVICE_ERASE);
        repeat (2) begin
            @(posedge clk) #1 rd_stb = 1'b1;
            rd_byte = rnd();
            @(posedge clk) #1 rd_stb = 1'b0;
            rdb_m = rd_byte;
            u_host.idle(3);
            data_rd();
        end
        @(posedge clk) #1 halt = 1'b0;
        repeat (3) @(posedge clk);
        u_host.idle(3);
        check("stall", {7'h00, stall}, 8'h00);
        check("user_en", {7'h00, user_en}, 8'h01);
        u_host.frame(2'b00, 8'h00, r);
        check("oe_unhalted", 8'(oe_hits), 8'h00);
        give_verdict();
    end
    initial begin
        #200us fails++;
        give_verdict();
    end
endmodule // twd_debug_regs_tb
`default_nettype wire

// ---- twd_host_model.sv ----
`default_nettype none
module twd_host_model (
    output var logic  o_link_clk,  // host-driven link clock
    output wire logic o_link_line, // resolved data pin level
    input  wire logic i_dev_data,  // device drive value
    input  wire logic i_dev_oe     // device drive enable
);
    timeunit 1ns;
    timeprecision 100ps;
    logic host_en = 1'b1;
    logic host_val = 1'b0;
    logic last_q = 1'b0;
    // released pin shows the inverse of its last level so a stale bit never passes as fresh
    // no user logic drives the line here: while the device is running only the host moves it
    assign o_link_line = i_dev_oe ? i_dev_data : (host_en ? host_val : ~last_q);
    initial o_link_clk = 1'b0;
    always @(posedge o_link_clk) last_q <= o_link_line;
    // clock only driven into the device and stands still between frames
    task automatic tick(input logic en, input logic v, output logic s);
        host_en = en;
        host_val = v;
        #32 o_link_clk = 1'b1;
        #32 s = o_link_line;
        o_link_clk = 1'b0;
    endtask
    task automatic idle(input int n);
        logic s;
        repeat (n) tick(1'b1, 1'b0, s);
    endtask
    task automatic frame(input logic [1:0] op, input logic [7:0] wv, output logic [7:0] rv);
        logic s;
        rv = 8'h00;
        tick(1'b1, 1'b1, s);
        tick(1'b1, op[0], s);
        tick(1'b1, op[1], s);
        for (int k = 0; k < 8; k++) begin
            if (op[0]) tick(1'b1, wv[k], s);
            else begin
                tick(1'b0, 1'b0, s);
                rv[k] = s;
            end
        end
        if (!op[0]) tick(1'b0, 1'b0, s);
    endtask
endmodule // twd_host_model
`default_nettype wire

// ---- twd_pkg.sv ----
`default_nettype none
package twd_pkg;
    // target select codes
    localparam logic [7:0] TWD_SEL_IDENTITY = 8'h00;
    localparam logic [7:0] TWD_SEL_REVISION = 8'h01;
    localparam logic [7:0] TWD_SEL_CONTROL  = 8'h02;
    localparam logic [7:0] TWD_SEL_CHANNEL  = 8'hb4;
    // flash command codes carried by the channel
    localparam logic [7:0] TWD_CMD_BLOCK_READ  = 8'h06;
    localparam logic [7:0] TWD_CMD_BLOCK_WRITE = 8'h07;
    localparam logic [7:0] TWD_CMD_PAGE_ERASE  = 8'h08;
    localparam logic [7:0] TWD_CMD_DEVICE_ERASE = 8'h03;
    // reset values
    localparam logic [7:0] TWD_SELECT_RST  = 8'h00;
    localparam logic [7:0] TWD_CONTROL_RST = 8'h00;
    localparam logic [7:0] TWD_CHANNEL_RST = 8'h00;
    // bit counts inside a frame
    localparam logic [2:0] TWD_INSTR_LAST = 3'h1;
    localparam logic [2:0] TWD_WBYTE_LAST = 3'h7;
    localparam logic [2:0] TWD_RBYTE_LAST = 3'h6;

    typedef enum logic [1:0] {
        TWD_OP_DATA_RD = 2'b00,
        TWD_OP_ADDR_WR = 2'b01,
        TWD_OP_ADDR_RD = 2'b10,
        TWD_OP_DATA_WR = 2'b11
    } twd_op_t;

    typedef enum logic [2:0] {
        TWD_L_IDLE  = 3'b000,
        TWD_L_INSTR = 3'b001,
        TWD_L_WDATA = 3'b010,
        TWD_L_TURN  = 3'b011,
        TWD_L_RDATA = 3'b100,
        TWD_L_STOP  = 3'b101
    } twd_link_st_t;

    typedef enum logic [2:0] {
        TWD_F_NONE         = 3'b000,
        TWD_F_BLOCK_READ   = 3'b001,
        TWD_F_BLOCK_WRITE  = 3'b010,
        TWD_F_PAGE_ERASE   = 3'b011,
        TWD_F_DEVICE_ERASE = 3'b100
    } twd_fcmd_t;

    typedef enum logic {
        TWD_C_WAIT_CMD = 1'b0,
        TWD_C_ARGS     = 1'b1
    } twd_chan_st_t;

    typedef struct packed {
        logic      cmd_stb;
        twd_fcmd_t cmd;
        logic      bad_stb;
        logic      arg_stb;
        logic [7:0] arg;
    } twd_flash_req_t;
endpackage
`default_nettype wire
